// *** verilog/pps_port_supervisor.sv ***
/*
 * Supervisory logic of a four-port power controller: port power gating,
 * limit-code selection, load-removal timers, event latching, interrupt,
 * an Avalon-MM register slave and a sampled two/three-wire serial slave.
 * Assumes analog comparators deliver the sense levels as asynchronous pins
 * and that the serial clock is much slower than clk.
 */
module pps_port_supervisor #(
	parameter logic [pps_pkg::CNT_W-1:0] SUP_CYC =
		pps_pkg::CNT_W'(pps_pkg::SUP_GOOD_MS * pps_pkg::CLK_KHZ + 1),
	parameter logic [pps_pkg::CNT_W-1:0] REM_CYC =
		pps_pkg::CNT_W'(pps_pkg::REM_WAIT_MS * pps_pkg::CLK_KHZ + 1)
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [3:0]  port_shutdown_n,
	input  wire logic [11:0] class_result,
	input  wire logic [3:0]  dc_below,
	input  wire logic [3:0]  ac_below,
	input  wire logic [3:0]  start_fault,
	input  wire logic        logic_supply_lockout,
	input  wire logic        main_supply_good,
	input  wire logic        main_supply_over_flag,
	input  wire logic        main_supply_under_flag,
	input  wire logic        logic_supply_under_flag,
	input  wire logic        logic_supply_over_flag,
	input  wire logic        ac_probe_low,
	input  wire logic        over_temp,
	input  wire logic        addr_strap_3,
	input  wire logic        addr_strap_2,
	input  wire logic        addr_strap_1,
	input  wire logic        addr_strap_0,
	input  wire logic        serial_clk,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	output logic             int_out,
	output logic             int_out_oe,
	output logic      [3:0]  port_power_en,
	output logic      [11:0] current_limit_code,
	output logic      [3:0]  dc_removal_watch_en,
	output logic      [3:0]  ac_removal_watch_en,
	output logic      [2:0]  ac_current_threshold
);
	import pps_pkg::*;

	pps_state_t q;
	pps_state_t n;
	logic [1:0] rs_q;
	logic       rst_ok;
	logic       rdy;
	logic       core_rst;
	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic       addr_hit;
	logic       i2c_rd;
	logic       i2c_wr;
	logic       av_go;
	logic       acc_rd;
	logic       acc_wr;
	logic [7:0] acc_idx;
	logic [7:0] acc_wd;
	logic [7:0] rd_val;
	logic [7:0] summary;
	logic [3:0] hit;
	logic [3:0] ld_set;
	logic [7:0] sup_set;
	logic [7:0] wr_on;

	// Saturating count, shared by the supply and removal timers.
	function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v,
		input logic [CNT_W-1:0] lim);
		inc_sat = (v < lim) ? v + 1'b1 : v;
	endfunction

	// Pointer step; it parks at the last address instead of wrapping.
	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		ptr_next = (p < PTR_LAST) ? p + 1'b1 : p;
	endfunction

	// Limit code from a class result; high-power classes stay at default.
	function automatic logic [2:0] auto_code(input logic [2:0] c);
		case (c)
			CLS_1:   auto_code = LIM_CLS1;
			CLS_2:   auto_code = LIM_CLS2;
			default: auto_code = LIM_DEF;
		endcase
	endfunction

	// Reset release through two flops so no flop leaves reset mid-edge.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_ok = rs_q[1];

	// Decoded conditions used by several processes below.
	assign rdy      = (q.sup_cnt == SUP_CYC);
	assign core_rst = !rdy || q.s2.lock || (q.hot_seen && !q.s2.hot) ||
		q.sw_rst;
	assign rise     = q.s2.scl && !q.scl_d;
	assign fall     = !q.s2.scl && q.scl_d;
	assign start_c  = q.s2.scl && q.scl_d && q.sda_d && !q.s2.sda;
	assign stop_c   = q.s2.scl && q.scl_d && !q.sda_d && q.s2.sda;
	assign addr_hit = (q.sh[7:1] == {DEV_ADDR_HI, q.strap_q}) ||
		(q.sh[7:1] == GLOBAL_ADDR);
	assign summary  = {|q.sup_ev, |q.sf_ev, 3'h0, |q.ld_ev, 2'h0};

	// The serial slave takes priority; a colliding Avalon request waits.
	assign i2c_wr  = !start_c && !stop_c && fall && q.st == I_WRX &&
		q.cnt == BITS_BYTE && q.have_cmd;
	assign i2c_rd  = !start_c && !stop_c && fall &&
		((q.st == I_ACK && q.rw) || (q.st == I_RACK && q.rack));
	assign av_go   = (avs_read || avs_write) && !q.av_ack &&
		!i2c_wr && !i2c_rd;
	assign acc_rd  = i2c_rd || (av_go && avs_read);
	assign acc_wr  = i2c_wr || (av_go && avs_write && avs_byteenable[0]);
	assign acc_idx = (i2c_rd || i2c_wr) ? q.ptr : avs_address[9:2];
	assign acc_wd  = i2c_wr ? q.sh : avs_writedata[7:0];
	assign wr_on   = acc_wr ? acc_wd : 8'h00;
	assign avs_waitrequest = (avs_read || avs_write) && !q.av_ack;

	// Register read map; alias and clear-on-read share contents.
	always_comb begin
		case (acc_idx)
			R_INT:     rd_val = summary;
			R_MASK:    rd_val = q.mask;
			R_LD_RO,
			R_LD_COR:  rd_val = {q.ld_ev, 4'h0};
			R_SF_RO,
			R_SF_COR:  rd_val = {4'h0, q.sf_ev};
			R_SUP_RO,
			R_SUP_COR: rd_val = q.sup_ev;
			R_STAT:    rd_val = {2'h0, q.s2.hot, q.s2.osc_bad, q.pwr};
			R_ADDR:    rd_val = {1'b0, DEV_ADDR_HI, q.strap_q};
			R_DISC_EN: rd_val = {q.ac_en, q.dc_en};
			R_CFG:     rd_val = q.cfg;
			R_ACTH:    rd_val = {5'h0, q.acth};
			R_LIM_A:   rd_val = {1'b0, q.lim[1], 1'b0, q.lim[0]};
			R_LIM_B:   rd_val = {1'b0, q.lim[3], 1'b0, q.lim[2]};
			default:   rd_val = 8'h00;
		endcase
	end

	// Removal timer hits and load events, one per port, and supply event sources.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			hit[i]    = q.rem_cnt[i] == REM_CYC;
			ld_set[i] = q.pwr[i] && hit[i];
		end
		// Under/over warnings other than main_over only set flags; main_over, hot and osc_bad (with ac_en) also cut power.
		sup_set = {q.s2.main_over, q.s2.logic_over, q.s2.logic_under,
			q.s2.main_under, 1'b0, q.s2.hot, q.s2.osc_bad,
			q.lock_seen && !core_rst};
	end

	// Next-state logic for the whole block.
	always_comb begin
		n = q;
		n.s1 = {port_shutdown_n, class_result, dc_below, ac_below,
			start_fault, logic_supply_lockout, main_supply_good,
			main_supply_over_flag, main_supply_under_flag,
			logic_supply_under_flag, logic_supply_over_flag, ac_probe_low,
			over_temp, addr_strap_3, addr_strap_2, addr_strap_1,
			addr_strap_0, serial_clk, serial_data_in};
		n.s2 = q.s1;
		n.scl_d = q.s2.scl;
		n.sda_d = q.s2.sda;
		n.core_d = core_rst;
		n.av_ack = av_go;
		if (av_go && avs_read) begin
			n.av_rd = rd_val;
		end
		n.sup_cnt = q.s2.main_good ? inc_sat(q.sup_cnt, SUP_CYC) :
			{CNT_W{1'b0}};
		if (q.s2.lock) begin
			n.lock_seen = 1'b1;
		end else if (!core_rst) begin
			n.lock_seen = 1'b0;
		end
		if (q.s2.hot) begin
			n.hot_seen = 1'b1;
		end else if (core_rst) begin
			n.hot_seen = 1'b0;
		end
		if (q.core_d && !core_rst) begin
			n.strap_q = q.s2.strap;
		end

		// Software writes to control registers.
		if (acc_wr) begin
			case (acc_idx)
				R_MASK:    n.mask = acc_wd;
				R_DISC_EN: begin
					n.dc_en = acc_wd[3:0];
					n.ac_en = acc_wd[7:4];
				end
				R_CFG:     n.cfg = acc_wd;
				R_ACTH:    n.acth = acc_wd[2:0];
				R_LIM_A:   begin
					n.lim[0] = acc_wd[2:0];
					n.lim[1] = acc_wd[6:4];
				end
				R_LIM_B:   begin
					n.lim[2] = acc_wd[2:0];
					n.lim[3] = acc_wd[6:4];
				end
				default:   n.sw_rst = acc_idx == R_CLR &&
					acc_wd[CLR_SWRST_B];
			endcase
		end
		// Automatic selection overrides host codes every cycle.
		if (q.cfg[CFG_AUTO_B]) begin
			for (int i = 0; i < 4; i++) begin
				n.lim[i] = auto_code(q.s2.cls[3*i +: 3]);
			end
		end

		// Port power and removal timers per port; events follow below.
		for (int i = 0; i < 4; i++) begin
			n.rem_cnt[i] = (q.pwr[i] && ((q.dc_en[i] && q.s2.dc_low[i]) ||
				(q.ac_en[i] && q.s2.ac_low[i]))) ?
				inc_sat(q.rem_cnt[i], REM_CYC) : {CNT_W{1'b0}};
			if (wr_on[i] && acc_idx == R_PWR) begin
				n.pwr[i] = 1'b1;
			end
			if (core_rst || q.s2.main_over || q.s2.hot ||
				!q.s2.shd_n[i] || hit[i] || q.s2.st_flt[i] ||
				(q.ac_en[i] && q.s2.osc_bad) ||
				(wr_on[i + 4] && acc_idx == R_PWR)) begin
				n.pwr[i] = 1'b0;
			end
		end

		// Events: clear first, then a same-cycle set wins over the clear.
		if (acc_rd && acc_idx == R_LD_COR) begin
			n.ld_ev = 4'h0;
		end
		if (acc_rd && acc_idx == R_SF_COR) begin
			n.sf_ev = 4'h0;
		end
		if (acc_rd && acc_idx == R_SUP_COR) begin
			n.sup_ev = 8'h00;
		end
		if (acc_idx == R_CLR && wr_on[CLR_ALL_B]) begin
			n.ld_ev  = 4'h0;
			n.sf_ev  = 4'h0;
			n.sup_ev = 8'h00;
		end
		n.ld_ev  = (n.ld_ev | ld_set) & q.s2.shd_n;
		n.sf_ev  = (n.sf_ev | q.s2.st_flt) & q.s2.shd_n;
		n.sup_ev = n.sup_ev | sup_set;

		// Open-drain interrupt follows unmasked summary bits.
		n.int_oe = q.cfg[CFG_INT_EN_B] &&
			|(summary & q.mask);

		// Serial slave: sampled on clk, only ever drives data low.
		if (start_c) begin
			n.st = I_ADDR;
			n.cnt = 4'h0;
			n.have_cmd = 1'b0;
			n.sda_oe = 1'b0;
		end else if (stop_c) begin
			n.st = I_IDLE;
			n.sda_oe = 1'b0;
		end else if (i2c_rd) begin
			n.sh = rd_val;
			n.ptr = ptr_next(q.ptr);
			n.sda_oe = !rd_val[7];
			n.cnt = 4'h0;
			n.st = I_RDX;
		end else begin
			case (q.st)
				I_ADDR, I_WRX: begin
					if (rise && q.cnt != BITS_BYTE) begin
						n.sh = {q.sh[6:0], q.s2.sda};
						n.cnt = q.cnt + 1'b1;
					end
					if (fall && q.cnt == BITS_BYTE) begin
						n.st = I_ACK;
						n.sda_oe = 1'b1;
						if (q.st == I_ADDR) begin
							n.rw = q.sh[0];
							if (!addr_hit) begin
								n.st = I_IDLE;
								n.sda_oe = 1'b0;
							end
						end else begin
							n.rw = 1'b0;
							n.have_cmd = 1'b1;
							n.ptr = q.have_cmd ? ptr_next(q.ptr) : q.sh;
						end
					end
				end
				I_ACK: begin
					if (fall) begin
						n.sda_oe = 1'b0;
						n.cnt = 4'h0;
						n.st = I_WRX;
					end
				end
				I_RDX: begin
					if (rise) begin
						n.sh = {q.sh[6:0], 1'b0};
						n.cnt = q.cnt + 1'b1;
					end
					if (fall) begin
						n.sda_oe = (q.cnt == BITS_BYTE) ? 1'b0 : !q.sh[7];
						n.st = (q.cnt == BITS_BYTE) ? I_RACK : I_RDX;
					end
				end
				I_RACK: begin
					if (rise) begin
						n.rack = !q.s2.sda;
					end
					if (fall) begin
						n.st = I_IDLE;
					end
				end
				default: begin
					n.st = I_IDLE;
					n.sda_oe = 1'b0;
				end
			endcase
		end

		// Core reset returns control and event state to defaults.
		if (core_rst) begin
			n.pwr    = 4'h0;
			n.ld_ev  = 4'h0;
			n.sf_ev  = 4'h0;
			n.sup_ev = {7'h00, q.s2.lock || q.lock_seen};
			n.mask   = 8'h00;
			n.cfg    = CFG_RST;
			n.dc_en  = 4'h0;
			n.ac_en  = 4'h0;
			n.acth   = 3'h0;
			n.lim    = '0;
			n.sw_rst = 1'b0;
		end
	end

	// Single state register; async reset loads constants only.
	always_ff @(posedge clk or negedge rst_ok) begin
		if (!rst_ok) begin
			q    <= '0;
			q.st <= I_IDLE;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from flops, except serial_data_out and int_out, tied low.
	assign avs_readdata         = {24'h0, q.av_rd};
	assign serial_data_out      = 1'b0;
	assign serial_data_out_oe   = q.sda_oe;
	assign int_out              = 1'b0;
	assign int_out_oe           = q.int_oe;
	assign port_power_en        = q.pwr;
	assign current_limit_code   = q.lim;
	assign dc_removal_watch_en  = q.dc_en;
	assign ac_removal_watch_en  = q.ac_en;
	assign ac_current_threshold = q.acth;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_ok);

	chk_auto_code: assert property (
		q.cfg[CFG_AUTO_B] && !core_rst && q.s2.cls[2:0] == CLS_1
		|=> q.lim[0] == LIM_CLS1)
		else $error("auto limit code not loaded");
	chk_shd_off: assert property (
		!q.s2.shd_n[1] |=> !q.pwr[1] && !q.ld_ev[1] && !q.sf_ev[1])
		else $error("shutdown did not drop port");
	chk_int_mask: assert property (
		(summary & q.mask) == 8'h00 |=> !q.int_oe)
		else $error("masked event drove interrupt");
	chk_int_level: assert property (
		q.cfg[CFG_INT_EN_B] && |(summary & q.mask) && !core_rst
		|=> q.int_oe)
		else $error("interrupt not asserted");
	chk_cor_clear: assert property (
		acc_rd && acc_idx == R_SF_COR && q.s2.st_flt == 4'h0
		|=> q.sf_ev == 4'h0)
		else $error("clear-on-read left events");
	chk_alias_keep: assert property (
		acc_rd && acc_idx == R_SF_RO && !core_rst && &q.s2.shd_n
		|=> (q.sf_ev & $past(q.sf_ev)) == $past(q.sf_ev))
		else $error("alias read cleared events");
	chk_clear_all: assert property (
		acc_wr && acc_idx == R_CLR && acc_wd[CLR_ALL_B] &&
		q.s2.st_flt == 4'h0 && ld_set == 4'h0 |=> q.ld_ev == 4'h0 &&
		q.sf_ev == 4'h0)
		else $error("clear bit left events");
	chk_main_over: assert property (
		q.s2.main_over |=> q.pwr == 4'h0)
		else $error("overvoltage left a port on");
	chk_osc_refuse: assert property (
		q.s2.osc_bad && q.ac_en[2] |=> !q.pwr[2])
		else $error("port powered with oscillator failed");
	chk_removal: assert property (
		q.pwr[0] && hit[0] && &q.s2.shd_n |=> !q.pwr[0] && q.ld_ev[0])
		else $error("load removal not acted on");
	chk_supply_wait: assert property (
		!q.s2.main_good |=> ##1 q.pwr == 4'h0 [*2])
		else $error("port on without supply good");
	chk_addr_ack: assert property (
		q.st == I_ADDR && fall && !start_c && !stop_c &&
		q.cnt == BITS_BYTE && q.sh[7:1] == {DEV_ADDR_HI, q.strap_q}
		|=> q.sda_oe && q.st == I_ACK)
		else $error("own address not acknowledged");
endmodule

// *** verilog/pps_pkg.sv ***
/*
 * Shared constants and types for the four-port power supervisor: register
 * indexes, field positions, reset values, limit codes and timing figures.
 * Assumes a 50 MHz core clock and a byte address of four times the index.
 */
package pps_pkg;
	localparam int          CNT_W        = 24;
	localparam int          CLK_KHZ      = 50000;
	localparam int          SUP_GOOD_MS  = 3;
	localparam int          REM_WAIT_MS  = 300;
	// Register indexes.
	localparam logic [7:0]  R_INT        = 8'h00;
	localparam logic [7:0]  R_MASK       = 8'h01;
	localparam logic [7:0]  R_LD_RO      = 8'h06;
	localparam logic [7:0]  R_LD_COR     = 8'h07;
	localparam logic [7:0]  R_SF_RO      = 8'h08;
	localparam logic [7:0]  R_SF_COR     = 8'h09;
	localparam logic [7:0]  R_SUP_RO     = 8'h0A;
	localparam logic [7:0]  R_SUP_COR    = 8'h0B;
	localparam logic [7:0]  R_STAT       = 8'h10;
	localparam logic [7:0]  R_ADDR       = 8'h11;
	localparam logic [7:0]  R_DISC_EN    = 8'h13;
	localparam logic [7:0]  R_CFG        = 8'h17;
	localparam logic [7:0]  R_PWR        = 8'h19;
	localparam logic [7:0]  R_CLR        = 8'h1A;
	localparam logic [7:0]  R_ACTH       = 8'h23;
	localparam logic [7:0]  R_LIM_A      = 8'h2A;
	localparam logic [7:0]  R_LIM_B      = 8'h2B;
	localparam logic [7:0]  PTR_LAST     = 8'h26;
	// Field positions.
	localparam int          INT_SUP_B    = 7;
	localparam int          INT_SF_B     = 6;
	localparam int          INT_LD_B     = 2;
	localparam int          CFG_INT_EN_B = 7;
	localparam int          CFG_AUTO_B   = 2;
	localparam int          CLR_ALL_B    = 7;
	localparam int          CLR_SWRST_B  = 4;
	localparam int          STAT_OSC_B   = 4;
	localparam int          STAT_HOT_B   = 5;
	localparam logic [7:0]  CFG_RST      = 8'h80;
	// Limit codes and class results.
	localparam logic [2:0]  CLS_1        = 3'h1;
	localparam logic [2:0]  CLS_2        = 3'h2;
	localparam logic [2:0]  LIM_CLS1     = 3'h6;
	localparam logic [2:0]  LIM_CLS2     = 3'h7;
	localparam logic [2:0]  LIM_DEF      = 3'h0;
	// Serial bus addressing.
	localparam logic [2:0]  DEV_ADDR_HI  = 3'h2;
	localparam logic [6:0]  GLOBAL_ADDR  = 7'h30;
	localparam logic [3:0]  BITS_BYTE    = 4'h8;

	typedef enum logic [5:0] {
		I_IDLE = 6'h01,
		I_ADDR = 6'h02,
		I_ACK  = 6'h04,
		I_WRX  = 6'h08,
		I_RDX  = 6'h10,
		I_RACK = 6'h20
	} pps_bus_st_t;

	typedef struct packed {
		logic [3:0]  shd_n;
		logic [11:0] cls;
		logic [3:0]  dc_low;
		logic [3:0]  ac_low;
		logic [3:0]  st_flt;
		logic        lock;
		logic        main_good;
		logic        main_over;
		logic        main_under;
		logic        logic_under;
		logic        logic_over;
		logic        osc_bad;
		logic        hot;
		logic [3:0]  strap;
		logic        scl;
		logic        sda;
	} pps_pins_t;

	typedef struct packed {
		pps_pins_t             s1;
		pps_pins_t             s2;
		logic                  scl_d;
		logic                  sda_d;
		logic                  core_d;
		logic [CNT_W-1:0]      sup_cnt;
		logic                  lock_seen;
		logic                  hot_seen;
		logic [3:0]            strap_q;
		logic [3:0]            pwr;
		logic [3:0][CNT_W-1:0] rem_cnt;
		logic [3:0]            ld_ev;
		logic [3:0]            sf_ev;
		logic [7:0]            sup_ev;
		logic [7:0]            mask;
		logic [7:0]            cfg;
		logic [3:0]            dc_en;
		logic [3:0]            ac_en;
		logic [2:0]            acth;
		logic [3:0][2:0]       lim;
		logic                  sw_rst;
		logic                  int_oe;
		pps_bus_st_t           st;
		logic [3:0]            cnt;
		logic [7:0]            sh;
		logic                  rw;
		logic                  have_cmd;
		logic                  rack;
		logic [7:0]            ptr;
		logic                  sda_oe;
		logic                  av_ack;
		logic [7:0]            av_rd;
	} pps_state_t;
endpackage

// *** dv/pps_host_model.sv ***
/*
 * Serial bus master model for the port supervisor: START, a byte sent or
 * read with its acknowledge clock, STOP, at a bit period of eight cycles.
 * Assumes the shared data line has a pull-up and is passed in as sdo_line.
 */
module pps_host_model (
	input  wire logic clk,
	input  wire logic sdo_line,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// The bus idles with both lines high and the clock standing still.
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Only the master opens and closes frames and makes the clock.
	task automatic start_c();
		sda <= 1'b0;
		wt(4);
		scl <= 1'b0;
		wt(2);
	endtask
	task automatic stop_c();
		sda <= 1'b0;
		wt(2);
		scl <= 1'b1;
		wt(4);
		sda <= 1'b1;
		wt(4);
	endtask
	// Data moves mid-low so it never changes while the clock is high.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda <= (i == 0) ? 1'b1 : b[i-1];
			wt(2);
			scl <= 1'b1;
			wt(4);
			ack = ~sdo_line;
			scl <= 1'b0;
			wt(2);
		end
	endtask
	// Reads one byte MSB first; the ninth clock carries a not-acknowledge.
	task automatic get_byte(output logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			sda <= 1'b1;
			wt(2);
			scl <= 1'b1;
			wt(4);
			if (i > 0) begin
				b[i-1] = sdo_line;
			end
			scl <= 1'b0;
			wt(2);
		end
	endtask
endmodule

// *** dv/pps_port_supervisor_tb.sv ***
/*
 * Self-checking bench for the port supervisor: register accesses over
 * Avalon-MM, serial frames through the host model, analog levels as pins.
 * Assumes short supply and removal counts of 20 and 10 cycles.
 */
module pps_port_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pps_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [9:0]  avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic        sdo, sdo_oe, int_oe, h_scl, h_sda, sdo_line, irq;
	logic [3:0]  sflt = 4'h0, dwe, awe;
	logic [3:0]  shd_n = 4'hF, strap = 4'hA, dcb = '0, acb = '0, pwr;
	logic [11:0] lim;
	logic [2:0]  thr;
	logic        lock = 0, good = 0, v_ov = 0, v_uv = 0, l_uv = 0;
	logic        l_ov = 0, osc = 0, hot = 0;
	int          errors = 0, tests_run = 0, cyc = 0;

	always #10 clk = ~clk;
	// Pull-up on the shared data line; the slave can only pull it low.
	assign sdo_line = sdo_oe ? sdo : 1'b1;

	pps_port_supervisor #(
		.SUP_CYC(24'h000014),
		.REM_CYC(24'h00000A)
	) i_pps_port_supervisor (
		.clk, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
		.avs_waitrequest, .port_shutdown_n(shd_n),
		.class_result(12'h611), .dc_below(dcb), .ac_below(acb),
		.start_fault(sflt), .logic_supply_lockout(lock),
		.main_supply_good(good), .main_supply_over_flag(v_ov),
		.main_supply_under_flag(v_uv), .logic_supply_under_flag(l_uv),
		.logic_supply_over_flag(l_ov), .ac_probe_low(osc),
		.over_temp(hot), .addr_strap_3(strap[3]),
		.addr_strap_2(strap[2]), .addr_strap_1(strap[1]),
		.addr_strap_0(strap[0]), .serial_clk(h_scl),
		.serial_data_in(h_sda & sdo_line), .serial_data_out(sdo),
		.serial_data_out_oe(sdo_oe), .int_out(irq), .int_out_oe(int_oe),
		.port_power_en(pwr), .current_limit_code(lim),
		.dc_removal_watch_en(dwe), .ac_removal_watch_en(awe),
		.ac_current_threshold(thr)
	);
	pps_host_model i_pps_host_model (
		.clk, .sdo_line, .scl(h_scl), .sda(h_sda)
	);

	task automatic stop_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One Avalon transfer, held until waitrequest is seen low at an edge.
	task automatic av(input logic wr, input logic [7:0] i,
		input logic [7:0] d, output logic [7:0] q);
		avs_address <= {i, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic w(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		av(1'b1, i, d, q);
		cy(3);
	endtask
	task automatic r(input logic [7:0] i, output logic [7:0] q);
		av(1'b0, i, 8'h00, q);
	endtask
	// Cut a hang short; the run should take about 1100 cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end

	initial begin
		logic       a;
		logic [7:0] q;
		cy(8);
		rst_b <= 1'b1;
		cy(3);
		w(R_PWR, 8'h01);
		chk(pwr, 4'h0);
		good <= 1'b1;
		cy(8);
		w(R_PWR, 8'h01);
		chk(pwr, 4'h0);
		cy(30);
		w(R_PWR, 8'h01);
		chk(pwr, 4'h1);
		r(R_ADDR, q);
		chk(q, 8'h2A);
		// Own address, a stranger's address, then the global call.
		i_pps_host_model.start_c();
		i_pps_host_model.put_byte(8'h54, a);
		chk(a, 1'b1);
		i_pps_host_model.put_byte(R_MASK, a);
		i_pps_host_model.put_byte(8'h04, a);
		i_pps_host_model.stop_c();
		r(R_MASK, q);
		chk(q, 8'h04);
		i_pps_host_model.start_c();
		i_pps_host_model.put_byte(8'h56, a);
		chk(a, 1'b0);
		i_pps_host_model.stop_c();
		i_pps_host_model.start_c();
		i_pps_host_model.put_byte(8'h60, a);
		chk(a, 1'b1);
		i_pps_host_model.stop_c();
		// Point at the address register, then read it back serially.
		i_pps_host_model.start_c();
		i_pps_host_model.put_byte(8'h54, a);
		i_pps_host_model.put_byte(R_ADDR, a);
		i_pps_host_model.stop_c();
		i_pps_host_model.start_c();
		i_pps_host_model.put_byte(8'h55, a);
		chk(a, 1'b1);
		i_pps_host_model.get_byte(q);
		i_pps_host_model.stop_c();
		chk(q, 8'h2A);
		chk(sdo, 1'b0);
		chk(irq, 1'b0);
		w(R_CFG, 8'h84);
		chk(lim, 12'h03E);
		w(R_CFG, 8'h80);
		w(R_LIM_A, 8'h35);
		w(R_LIM_B, 8'h42);
		chk(lim, 12'h89D);
		w(R_PWR, 8'h0F);
		shd_n <= 4'hD;
		cy(4);
		chk(pwr, 4'hD);
		r(R_STAT, q);
		chk(q, 8'h0D);
		shd_n <= 4'hF;
		// DC removal on port 0, then alias and clear-on-read reads.
		w(R_DISC_EN, 8'h01);
		dcb <= 4'h1;
		cy(20);
		dcb <= 4'h0;
		chk(pwr, 4'hC);
		chk(int_oe, 1'b1);
		r(R_INT, q);
		chk(q, 8'h04);
		r(R_LD_RO, q);
		chk(q, 8'h10);
		chk(int_oe, 1'b1);
		r(R_LD_COR, q);
		chk(q, 8'h10);
		r(R_LD_RO, q);
		cy(2);
		chk(q, 8'h00);
		chk(int_oe, 1'b0);
		// AC removal on port 2 while the event is masked.
		w(R_MASK, 8'h00);
		w(R_ACTH, 8'h05);
		chk(thr, 3'h5);
		w(R_DISC_EN, 8'h40);
		chk({awe, dwe}, 8'h40);
		acb <= 4'h4;
		cy(20);
		acb <= 4'h0;
		chk(pwr, 4'h8);
		chk(int_oe, 1'b0);
		w(R_MASK, 8'h04);
		chk(int_oe, 1'b1);
		w(R_CLR, 8'h80);
		chk(int_oe, 1'b0);
		r(R_LD_RO, q);
		chk(q, 8'h00);
		w(R_PWR, 8'h07);
		osc <= 1'b1;
		cy(6);
		chk(pwr, 4'hB);
		w(R_PWR, 8'h04);
		chk(pwr, 4'hB);
		osc <= 1'b0;
		cy(3);
		r(R_SUP_COR, q);
		chk(q, 8'h02);
		{v_uv, l_uv, l_ov} <= 3'h7;
		cy(6);
		{v_uv, l_uv, l_ov} <= 3'h0;
		chk(pwr, 4'hB);
		r(R_SUP_COR, q);
		chk(q, 8'h70);
		v_ov <= 1'b1;
		cy(6);
		chk(pwr, 4'h0);
		v_ov <= 1'b0;
		cy(3);
		w(R_PWR, 8'h01);
		chk(pwr, 4'h1);
		hot <= 1'b1;
		cy(6);
		chk(pwr, 4'h0);
		hot <= 1'b0;
		cy(40);
		r(R_MASK, q);
		chk(q, 8'h00);
		w(R_PWR, 8'h01);
		strap <= 4'h5;
		lock <= 1'b1;
		cy(6);
		chk(pwr, 4'h0);
		lock <= 1'b0;
		cy(40);
		r(R_SUP_RO, q);
		chk(q[0], 1'b1);
		r(R_ADDR, q);
		chk(q, 8'h25);
		// Startup fault on port 3: alias, clear-on-read, then soft reset.
		sflt <= 4'h8;
		cy(4);
		sflt <= 4'h0;
		cy(3);
		r(R_SF_RO, q);
		chk(q, 8'h08);
		r(R_SF_COR, q);
		chk(q, 8'h08);
		r(R_SF_RO, q);
		chk(q, 8'h00);
		sflt <= 4'h8;
		cy(4);
		sflt <= 4'h0;
		cy(3);
		w(R_CLR, 8'h10);
		r(R_SF_RO, q);
		chk(q, 8'h00);
		stop_test();
	end
endmodule
